// *** hw/udbt_regs.sv ***
/*
  Register slice of an asynchronous serial port: baud divisor, auxiliary
  timer, transmit and receive words and interrupt enables, on an
  Avalon-MM slave with waitrequest.
  Assumes flag, parity-mode and break-mode signals come from neighbouring
  logic on the same clock; frame shifters live outside.
*/
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module udbt_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [11:0] statusFlags,
  input wire logic txTaken,
  input wire logic customParity,
  input wire logic linBreakMode,
  input wire logic rxLoad,
  input wire logic [8:0] rxData,
  input wire logic timerStart,
  output logic [8:0] txData,
  output logic txCheckBit,
  output logic [8:0] txBreakLen,
  output logic txBufferEmpty,
  output logic timerOverflow,
  output logic timerRunning,
  output logic bitTick,
  output logic irq
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] baudInt, next_baudInt;
  logic [3:0] baudFrac, next_baudFrac;
  logic [23:0] tmrReload, next_tmrReload;
  logic [23:0] tmrCount;
  logic [8:0] txWord, next_txWord;
  logic [8:0] rxWord, next_rxWord;
  logic [11:0] irqMask, next_irqMask;
  logic txEmpty, next_txEmpty;
  logic ack, next_ack;
  logic [31:0] next_readdata;
  logic next_irq;
  logic [11:0] flags;
  logic [11:0] pend;
  logic wrDo;
  logic [31:0] wrVal;
  logic [31:0] rdMux;

  // merge write data into the old value lane by lane
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // one wait cycle on every access: read data is registered before
  // waitrequest drops, and writes commit one edge later, while waitrequest is low
  always_comb begin
    next_ack = (read || write) && !ack;
  end

  assign waitrequest = (read || write) && !ack;
  assign wrDo = write && ack;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else if (clkEn) begin
      ack <= next_ack;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // reserved bits and unmapped offsets read zero; the transmit word
  // is write-only and reads zero too
  always_comb begin
    rdMux = 32'h00000000;
    unique case (address)
      udbt_pkg::OFS_IRQ_MASK: rdMux[11:0] = irqMask;
      udbt_pkg::OFS_BAUD_INT: rdMux[15:0] = baudInt;
      udbt_pkg::OFS_BAUD_FRAC: rdMux[3:0] = baudFrac;
      udbt_pkg::OFS_TMR_RELOAD: rdMux[23:0] = tmrReload;
      udbt_pkg::OFS_TMR_COUNT: rdMux[23:0] = tmrCount;
      udbt_pkg::OFS_RX_WORD: rdMux[8:0] = rxWord;
      default: rdMux = 32'h00000000;
    endcase
    next_readdata = readdata;
    if (read && !ack) next_readdata = rdMux;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else if (clkEn) begin
      readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_comb begin
    next_baudInt = baudInt;
    next_baudFrac = baudFrac;
    next_tmrReload = tmrReload;
    next_txWord = txWord;
    next_irqMask = irqMask;
    wrVal = 32'h00000000;
    if (wrDo) begin
      unique case (address)
        udbt_pkg::OFS_BAUD_INT: begin
          wrVal = merge({16'h0000, baudInt}, writedata, byteenable);
          next_baudInt = wrVal[15:0];
        end
        udbt_pkg::OFS_BAUD_FRAC: begin
          wrVal = merge({28'h0000000, baudFrac}, writedata, byteenable);
          next_baudFrac = wrVal[3:0];
        end
        udbt_pkg::OFS_TMR_RELOAD: begin
          wrVal = merge({8'h00, tmrReload}, writedata, byteenable);
          next_tmrReload = wrVal[23:0];
        end
        udbt_pkg::OFS_TX_WORD: begin
          wrVal = merge({23'h0, txWord}, writedata, byteenable);
          next_txWord = wrVal[8:0];
        end
        udbt_pkg::OFS_IRQ_MASK: begin
          wrVal = merge({20'h00000, irqMask}, writedata, byteenable);
          // reserved enables cannot be set, whatever software writes
          next_irqMask = wrVal[11:0] & udbt_pkg::IRQ_WR_MASK;
        end
        default: wrVal = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      baudInt <= udbt_pkg::RST_BAUD_INT;
      baudFrac <= udbt_pkg::RST_BAUD_FRAC;
      tmrReload <= udbt_pkg::RST_TMR;
      txWord <= udbt_pkg::RST_WORD;
      irqMask <= udbt_pkg::RST_IRQ_MASK;
    end else if (clkEn) begin
      baudInt <= next_baudInt;
      baudFrac <= next_baudFrac;
      tmrReload <= next_tmrReload;
      txWord <= next_txWord;
      irqMask <= next_irqMask;
    end
  end

  // ---------------------------------------------------------------
  // transmit empty flag and receive word
  // ---------------------------------------------------------------
  // the shifter taking the word sets empty; if that lands on the same
  // edge as a new write, the set wins so the event is not lost
  always_comb begin
    next_txEmpty = txEmpty;
    if (wrDo && address == udbt_pkg::OFS_TX_WORD)
      next_txEmpty = 1'b0;
    if (txTaken)
      next_txEmpty = 1'b1;
    next_rxWord = rxLoad ? rxData : rxWord;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txEmpty <= udbt_pkg::RST_FLAGS[udbt_pkg::IRQ_TX_EMPTY];
      rxWord <= udbt_pkg::RST_WORD;
    end else if (clkEn) begin
      txEmpty <= next_txEmpty;
      rxWord <= next_rxWord;
    end
  end

  assign txBufferEmpty = txEmpty;
  assign txData = txWord;
  // check bit and break length are views of the same stored word
  assign txCheckBit = customParity & txWord[8];
  assign txBreakLen = linBreakMode ? txWord : 9'h000;

  // ---------------------------------------------------------------
  // baud divider and auxiliary timer
  // ---------------------------------------------------------------
  udbt_baud_gen #(
    .INT_W(udbt_pkg::BAUD_INT_W),
    .FRAC_W(udbt_pkg::BAUD_FRAC_W)
  ) u_baud (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .divInt(baudInt),
    .divFrac(baudFrac),
    .bitTick(bitTick)
  );

  udbt_aux_timer #(
    .W(udbt_pkg::TMR_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .start(timerStart),
    .reload(tmrReload),
    .count(tmrCount),
    .running(timerRunning)
  );

  // level, not sticky: it follows the compare directly
  assign timerOverflow = (tmrCount >= tmrReload);

  // ---------------------------------------------------------------
  // interrupt gating
  // ---------------------------------------------------------------
  // the empty and overflow flags are owned here, the rest come in
  always_comb begin
    flags = statusFlags;
    flags[udbt_pkg::IRQ_TX_EMPTY] = txEmpty;
    flags[udbt_pkg::IRQ_TMR_OVF] = timerOverflow;
  end

  for (genvar b = 0; b < udbt_pkg::IRQ_W; b++) begin : g_pend
    assign pend[b] = flags[b] & irqMask[b];
  end

  always_comb begin
    next_irq = |pend;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clkEn) begin
      irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_bus_answer: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((read || write) && waitrequest && clkEn) |=> !waitrequest)
    else $error("slave held waitrequest beyond one cycle");

  chk_mask_reserved: assert property (
    @(posedge sys_clk) disable iff (rst)
    (irqMask & ~udbt_pkg::IRQ_WR_MASK) == 12'h000)
    else $error("reserved enable bit set");

  chk_tx_empty_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clkEn && wrDo && address == udbt_pkg::OFS_TX_WORD && !txTaken)
    |=> !txBufferEmpty)
    else $error("transmit write left empty flag set");

  chk_irq_gate: assert property (
    @(posedge sys_clk) disable iff (rst)
    clkEn |=> (irq == |($past(flags) & $past(irqMask))))
    else $error("interrupt does not follow enabled flags");

  chk_reset_zero: assert property (
    @(posedge sys_clk)
    $past(rst) |-> (baudInt == 16'h0000 && irqMask == 12'h000
                    && tmrReload == 24'h000000 && rxWord == 9'h000))
    else $error("register not zero after reset");

  chk_rx_capture: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clkEn && rxLoad) |=> (rxWord == $past(rxData)))
    else $error("receive word not captured");

  chk_check_bit: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clkEn && wrDo && address == udbt_pkg::OFS_TX_WORD && byteenable[1])
    ##1 customParity |-> txCheckBit == $past(writedata[8]))
    else $error("check bit is not bit 8 of the written word");

  chk_break_len: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clkEn && wrDo && address == udbt_pkg::OFS_TX_WORD
     && byteenable[1:0] == 2'h3)
    ##1 linBreakMode |-> txBreakLen == $past(writedata[8:0]))
    else $error("break length does not follow transmit word");

  chk_count_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clkEn && read && !ack && address == udbt_pkg::OFS_TMR_COUNT)
    |=> readdata == {8'h00, $past(tmrCount)})
    else $error("count read does not return live count");
endmodule
`default_nettype wire

// *** shared/udbt_pkg.sv ***
/*
  Constants for the serial port data, divisor and timer register slice:
  byte offsets, field widths, enable bit positions, reset values and the
  timer state type.
  Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
*/
package udbt_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h08;
  localparam logic [5:0] OFS_BAUD_INT = 6'h0C;
  localparam logic [5:0] OFS_BAUD_FRAC = 6'h10;
  localparam logic [5:0] OFS_TMR_RELOAD = 6'h14;
  localparam logic [5:0] OFS_TMR_COUNT = 6'h18;
  localparam logic [5:0] OFS_RX_WORD = 6'h24;
  localparam logic [5:0] OFS_TX_WORD = 6'h28;

  // ---------------------------------------------------------------
  // field widths and reset values
  // ---------------------------------------------------------------
  localparam int BAUD_INT_W = 16;
  localparam int BAUD_FRAC_W = 4;
  localparam int TMR_W = 24;
  localparam int WORD_W = 9;
  localparam int IRQ_W = 12;
  localparam logic [15:0] RST_BAUD_INT = 16'h0000;
  localparam logic [3:0] RST_BAUD_FRAC = 4'h0;
  localparam logic [23:0] RST_TMR = 24'h000000;
  localparam logic [8:0] RST_WORD = 9'h000;
  localparam logic [11:0] RST_IRQ_MASK = 12'h000;

  // ---------------------------------------------------------------
  // interrupt enable bit positions
  // ---------------------------------------------------------------
  localparam int IRQ_TX_EMPTY = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_RX_DONE = 2;
  localparam int IRQ_FRAMING = 3;
  localparam int IRQ_CHECK_ERR = 4;
  localparam int IRQ_CTS = 6;
  localparam int IRQ_TMR_OVF = 9;
  localparam int IRQ_BAUD = 10;
  localparam int IRQ_BREAK_RX = 11;
  // writable enables; 8:7 and 5 stay zero
  localparam logic [11:0] IRQ_WR_MASK = 12'hE5F;
  localparam logic [11:0] RST_FLAGS = 12'h001;

  // ---------------------------------------------------------------
  // timer
  // ---------------------------------------------------------------
  localparam int TMR_EXTRA = 2;
  typedef enum logic {TMR_IDLE, TMR_RUN} udbt_tmr_state_t;
endpackage

// *** hw/udbt_baud_gen.sv ***
/*
  Bit period tick generator with a fractional divisor.
  Assumes divisors come from registers on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module udbt_baud_gen #(
  parameter int INT_W = 16,
  parameter int FRAC_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [INT_W-1:0] divInt,
  input wire logic [FRAC_W-1:0] divFrac,
  output logic bitTick
);
  if (INT_W < 2 || FRAC_W < 1) begin : g_bad
    $error("udbt_baud_gen: width too small");
  end

  logic [INT_W-1:0] cnt;
  logic [FRAC_W-1:0] acc;
  logic [INT_W-1:0] next_cnt;
  logic [FRAC_W-1:0] next_acc;
  logic next_bitTick;
  logic [FRAC_W:0] accSum;

  // ---------------------------------------------------------------
  // period counter with fraction dithering
  // ---------------------------------------------------------------
  // a carry out of the fraction stretches one bit by a cycle, so the
  // average period is int + frac/16 cycles
  always_comb begin
    accSum = {1'b0, acc} + {1'b0, divFrac};
    next_cnt = cnt;
    next_acc = acc;
    next_bitTick = 1'b0;
    if (divInt == '0) begin
      next_cnt = '0;
      next_acc = '0;
    end else if (cnt == '0) begin
      next_bitTick = 1'b1;
      next_acc = accSum[FRAC_W-1:0];
      next_cnt = divInt - INT_W'(1) + INT_W'(accSum[FRAC_W]);
    end else begin
      next_cnt = cnt - INT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= '0;
      acc <= '0;
      bitTick <= 1'b0;
    end else if (clkEn) begin
      cnt <= next_cnt;
      acc <= next_acc;
      bitTick <= next_bitTick;
    end
  end

  // helper: enabled cycles since the last tick
  logic [INT_W:0] gap;
  logic seen;
  logic [INT_W-1:0] lastInt;
  // a divisor change voids the period in flight, which still runs on
  // the old value, so the check waits for a period loaded afterwards
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap <= '0;
      seen <= 1'b0;
      lastInt <= '0;
    end else if (clkEn) begin
      gap <= bitTick ? (INT_W+1)'(1) : gap + (INT_W+1)'(1);
      seen <= (divInt != lastInt) ? 1'b0 : (seen | bitTick);
      lastInt <= divInt;
    end
  end

  chk_tick_spacing: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clkEn && bitTick && seen && $stable(divInt) && divInt > 1)
    |-> (gap >= {1'b0, divInt} && gap <= {1'b0, divInt} + 1))
    else $error("bit period outside int..int+1");
endmodule
`default_nettype wire

// *** hw/udbt_aux_timer.sv ***
/*
  Auxiliary timer in general timing mode: counts clock cycles from zero.
  Assumes start is a one-cycle pulse from control decoding.
*/
`timescale 1ns/100ps
`default_nettype none
module udbt_aux_timer #(
  parameter int W = 24
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic start,
  input wire logic [W-1:0] reload,
  output logic [W-1:0] count,
  output logic running
);
  if (W < 2) begin : g_bad
    $error("udbt_aux_timer: width too small");
  end

  udbt_pkg::udbt_tmr_state_t state, next_state;
  logic [W-1:0] next_count;
  logic [W:0] stopAt;

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  // compare one bit wider; only a reload of full scale is out of the count's
  // reach and parks the timer at its top value; one below full scale wraps to zero
  always_comb begin
    stopAt = {1'b0, reload} + (W+1)'(udbt_pkg::TMR_EXTRA);
    next_state = state;
    next_count = count;
    if (start) begin
      next_state = udbt_pkg::TMR_RUN;
      next_count = '0;
    end else begin
      unique case (state)
        udbt_pkg::TMR_IDLE: ;
        udbt_pkg::TMR_RUN: begin
          next_count = count + W'(1);
          if ({1'b0, count} + (W+1)'(1) >= stopAt) begin
            next_state = udbt_pkg::TMR_IDLE;
          end else if (&count) begin
            // the count must not wrap back to zero and run on
            next_count = count;
            next_state = udbt_pkg::TMR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= udbt_pkg::TMR_IDLE;
      count <= '0;
    end else if (clkEn) begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign running = (state == udbt_pkg::TMR_RUN);

  chk_timer_start: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clkEn && start) |=> (count == '0 && running))
    else $error("timer did not restart at zero");

  chk_timer_stop: assert property (
    @(posedge sys_clk) disable iff (rst)
    (clkEn && !start && running && $stable(reload)
     && {1'b0, count} + 1 == {1'b0, reload} + 2)
    |=> (!running && {1'b0, count} == $past({1'b0, reload}) + 2))
    else $error("timer did not stop at reload plus two");
endmodule
`default_nettype wire

// *** sim/udbt_far_node.sv ***
/*
  Far-side model of the serial port slice: stands in for the frame
  shifters and the remote node. It takes each transmit word after a
  chosen delay and hands receive words in on request.
  Assumes the bench sets takeDelay and calls sendRx by hierarchy.
*/
`timescale 1ns/100ps
`default_nettype none
module udbt_far_node (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic txBufferEmpty,
  input wire logic [8:0] txData,
  input wire logic [3:0] takeDelay,
  output logic txTaken,
  output logic rxLoad,
  output logic [8:0] rxData,
  output logic [8:0] lastTx
);
  logic [3:0] waitCnt;

  // take a pending word after takeDelay cycles; one take per empty flag
  always @(posedge sys_clk) begin
    txTaken <= 1'b0;
    if (rst) begin
      waitCnt <= 4'h0;
    end else if (!txBufferEmpty && !txTaken) begin
      if (waitCnt == takeDelay) begin
        txTaken <= 1'b1;
        lastTx <= txData;
        waitCnt <= 4'h0;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end

  initial begin
    rxLoad = 1'b0;
    rxData = 9'h155;
    lastTx = 9'h000;
  end

  // one-cycle load; afterwards the data lines no longer hold the word
  task automatic sendRx(input logic [8:0] d);
    @(posedge sys_clk);
    rxData <= d;
    rxLoad <= 1'b1;
    @(posedge sys_clk);
    rxLoad <= 1'b0;
    rxData <= ~d;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_udbt_regs.sv ***
/*
  Self-checking bench for the serial port register slice.
  Assumes the far-side model answers transmit words and feeds receives.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_udbt_regs;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'h0;
  logic [11:0] statusFlags = 12'h000;
  logic customParity = 1'b0;
  logic linBreakMode = 1'b0;
  logic timerStart = 1'b0;
  logic [3:0] takeDelay = 4'h0;
  logic [31:0] readdata;
  logic waitrequest, txTaken, rxLoad, txCheckBit, txBufferEmpty;
  logic timerOverflow, timerRunning, bitTick, irq;
  logic [8:0] rxData, txData, txBreakLen, lastTx;
  int miscompares = 0;
  int cmp_count = 0;
  localparam logic [5:0] OFS [8] = '{udbt_pkg::OFS_IRQ_MASK,
    udbt_pkg::OFS_BAUD_INT, udbt_pkg::OFS_BAUD_FRAC, udbt_pkg::OFS_TMR_RELOAD,
    udbt_pkg::OFS_TMR_COUNT, udbt_pkg::OFS_RX_WORD, udbt_pkg::OFS_TX_WORD,
    6'h30};
  localparam logic [31:0] ONES [8] = '{32'h00000E5F, 32'h0000FFFF,
    32'h0000000F, 32'h00FFFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

  udbt_regs i_udbt_regs (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .statusFlags(statusFlags), .txTaken(txTaken),
    .customParity(customParity), .linBreakMode(linBreakMode),
    .rxLoad(rxLoad), .rxData(rxData), .timerStart(timerStart),
    .txData(txData), .txCheckBit(txCheckBit), .txBreakLen(txBreakLen),
    .txBufferEmpty(txBufferEmpty), .timerOverflow(timerOverflow),
    .timerRunning(timerRunning), .bitTick(bitTick), .irq(irq));

  udbt_far_node i_udbt_far_node (.sys_clk(sys_clk), .rst(rst),
    .txBufferEmpty(txBufferEmpty), .txData(txData), .takeDelay(takeDelay),
    .txTaken(txTaken), .rxLoad(rxLoad), .rxData(rxData), .lastTx(lastTx));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] got,
                     input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // avalon cycle: hold everything until waitrequest is low at an edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    // sampled at the rising edge, before that edge's updates land
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) miscompares++;
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h0, q);
    chk("readdata", q, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd(OFS[i], 32'h0);
    chk("txBufferEmpty", txBufferEmpty, 1);
    chk("irq", irq, 0);
  endtask

  // 16 ticks at 4 + 8/16 cycles must span exactly 72 cycles
  task automatic t_baud();
    int n, k;
    wr(udbt_pkg::OFS_BAUD_INT, 32'h4);
    wr(udbt_pkg::OFS_BAUD_FRAC, 32'h8);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (bitTick !== 1'b1 && n < 200);
    n = 0;
    k = 0;
    while (k < 16 && n < 500) begin
      @(negedge sys_clk);
      n++;
      if (bitTick === 1'b1) k++;
    end
    chk("bit period sum", n, 72);
  endtask

  // all-ones to every place; reserved, read-only and unmapped stay zero
  task automatic t_access();
    logic [31:0] q;
    for (int i = 0; i < 8; i++) wr(OFS[i], 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) rd(OFS[i], ONES[i]);
    bus(1'b1, udbt_pkg::OFS_BAUD_INT, 32'h00001234, 4'h1, q);
    rd(udbt_pkg::OFS_BAUD_INT, 32'h0000FF34);
  endtask

  // slow far side, so the pending word can be watched before it goes
  task automatic t_tx();
    @(posedge sys_clk);
    takeDelay <= 4'hF;
    customParity <= 1'b1;
    linBreakMode <= 1'b1;
    wr(udbt_pkg::OFS_TX_WORD, 32'h000001A5);
    cyc(1);
    chk("txBufferEmpty", txBufferEmpty, 0);
    chk("txData", txData, 9'h1A5);
    chk("txCheckBit", txCheckBit, 1);
    chk("txBreakLen", txBreakLen, 9'h1A5);
    rd(udbt_pkg::OFS_TX_WORD, 32'h0);
    @(posedge sys_clk);
    customParity <= 1'b0;
    linBreakMode <= 1'b0;
    cyc(1);
    chk("txCheckBit", txCheckBit, 0);
    chk("txBreakLen", txBreakLen, 9'h000);
    cyc(30);
    chk("txBufferEmpty", txBufferEmpty, 1);
    chk("lastTx", lastTx, 9'h1A5);
  endtask

  task automatic t_rx();
    i_udbt_far_node.sendRx(9'h1C3);
    rd(udbt_pkg::OFS_RX_WORD, 32'h1C3);
    i_udbt_far_node.sendRx(9'h03C);
    rd(udbt_pkg::OFS_RX_WORD, 32'h03C);
  endtask

  task automatic t_timer();
    int n;
    wr(udbt_pkg::OFS_TMR_RELOAD, 32'h5);
    @(posedge sys_clk);
    timerStart <= 1'b1;
    @(posedge sys_clk);
    timerStart <= 1'b0;
    cyc(1);
    chk("timerRunning", timerRunning, 1);
    chk("timerOverflow", timerOverflow, 0);
    // with the enable low the timer must outlast its own stop point
    @(posedge sys_clk);
    clkEn <= 1'b0;
    cyc(12);
    chk("frozen timerRunning", timerRunning, 1);
    chk("frozen timerOverflow", timerOverflow, 0);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    n = 0;
    while (timerRunning === 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    chk("timerOverflow", timerOverflow, 1);
    rd(udbt_pkg::OFS_TMR_COUNT, 32'h7);
  endtask

  // each enable alone raises irq; all other enables but tx empty and overflow leave it low
  task automatic t_irq();
    logic [11:0] b1;
    for (int b = 1; b < 12; b++) begin
      if (b != 5 && b != 7 && b != 8 && b != 9) begin
        b1 = 12'h001 << b;
        @(posedge sys_clk);
        statusFlags <= b1;
        wr(udbt_pkg::OFS_IRQ_MASK, {20'h0, b1});
        cyc(3);
        chk("irq on", irq, 1);
        wr(udbt_pkg::OFS_IRQ_MASK, {20'h0, 12'hE5F & ~b1 & ~12'h201});
        cyc(3);
        chk("irq off", irq, 0);
      end
    end
    @(posedge sys_clk);
    statusFlags <= 12'h000;
    wr(udbt_pkg::OFS_IRQ_MASK, 32'h200);
    cyc(3);
    chk("irq overflow", irq, 1);
    wr(udbt_pkg::OFS_IRQ_MASK, 32'h001);
    cyc(3);
    chk("irq tx empty", irq, 1);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_baud();
    t_access();
    t_tx();
    t_rx();
    t_timer();
    t_irq();
    conclude();
  end
endmodule
`default_nettype wire
